//--- rtl/crt_ctrl.sv
// comparator-timer link and voltage reference control registers over ahb-lite
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "crt_cfg.svh"

// Contract
// - sync bit latches comparator on timer-clock fall
// - latch uses prescaler output when prescaled
// - timer rises, latch falls: no race unless the period is one clk
// - sync clear passes comparator output through
// - alt clock: 1 oscillator, 0 oscillator/4
// - gate source: 1 gate pin, 0 comparator
// - hysteresis bit enables comparator hysteresis
// - link register unused bits read zero
// - divider enable powers divider, selects it
// - range bit 1 low, 0 high range
// - four-bit level code selects divider tap
// - fast oscillator running forces fixed reference
// - both enables low with fast oscillator stopped gives ground reference
module crt_ctrl
  import crt_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cmp_out_raw,
  input wire logic timer_gate_pin,
  input wire logic fast_internal_osc,
  input wire logic prescaler_en,
  input wire logic [1:0] prescale_sel,
  output logic cmp_out_q,
  output logic timer_gate_q,
  output logic timer_tick_q,
  output logic cmp_hysteresis_en,
  output logic ratio_divider_en,
  output logic fixed_ref_on,
  output logic ref_range_sel,
  output logic [3:0] ref_level_code,
  output crt_ref_sel_t ref_sel_q
);

  // ****************************************
  // bus slave
  // ****************************************
  crt_link_t link_q;
  crt_vref_t vref_q;
  crt_phase_t phase_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wbyte;

  function automatic logic [7:0] link_to_byte(input crt_link_t l);
    logic [7:0] b;
    b = 8'h00;
    b[`CRT_SYNC_BIT] = l.sync_en;
    b[`CRT_GATE_BIT] = l.gate_source_sel;
    b[`CRT_HYS_BIT] = l.hysteresis_en;
    b[`CRT_ALTCLK_BIT] = l.alt_clock_sel;
    return b;
  endfunction

  function automatic logic [7:0] vref_to_byte(input crt_vref_t v);
    logic [7:0] b;
    b = 8'h00;
    b[`CRT_LEVEL_LSB +: 4] = v.ref_level_code;
    b[`CRT_FIXED_BIT] = v.fixed_ref_en;
    b[`CRT_RANGE_BIT] = v.ref_range_sel;
    b[`CRT_DIVEN_BIT] = v.ratio_divider_en;
    return b;
  endfunction

  assign wbyte = hwdata[7:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= CRT_PH_IDLE;
      addr_q <= '0;
    end else if (hready && hsel && htrans[1]) begin
      phase_q <= hwrite ? CRT_PH_WRITE : CRT_PH_READ;
      addr_q <= haddr[ADDR_W-1:0];
    end else if (hready) begin
      phase_q <= CRT_PH_IDLE;
    end
  end

  // writes land in the data phase; the slave never stalls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_q <= '0;
    end else if (phase_q == CRT_PH_WRITE && addr_q == `CRT_LINK_CTRL_OFS) begin
      link_q.sync_en <= wbyte[`CRT_SYNC_BIT];
      link_q.gate_source_sel <= wbyte[`CRT_GATE_BIT];
      link_q.hysteresis_en <= wbyte[`CRT_HYS_BIT];
      link_q.alt_clock_sel <= wbyte[`CRT_ALTCLK_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vref_q <= '0;
    end else if (phase_q == CRT_PH_WRITE && addr_q == `CRT_VREF_CTRL_OFS) begin
      vref_q.ref_level_code <= wbyte[`CRT_LEVEL_LSB +: 4];
      vref_q.fixed_ref_en <= wbyte[`CRT_FIXED_BIT];
      vref_q.ref_range_sel <= wbyte[`CRT_RANGE_BIT];
      vref_q.ratio_divider_en <= wbyte[`CRT_DIVEN_BIT];
    end
  end

  // read data registered at the address phase, so it stands in the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[ADDR_W-1:0] == `CRT_LINK_CTRL_OFS) begin
        hrdata <= {24'h00_0000, link_to_byte(link_q)};
      end else if (haddr[ADDR_W-1:0] == `CRT_VREF_CTRL_OFS) begin
        hrdata <= {24'h00_0000, vref_to_byte(vref_q)};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] cmp_s, gate_s, osc_s;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_s <= 2'b00;
      gate_s <= 2'b00;
      osc_s <= 2'b00;
    end else begin
      cmp_s <= {cmp_s[0], cmp_out_raw};
      gate_s <= {gate_s[0], timer_gate_pin};
      osc_s <= {osc_s[0], fast_internal_osc};
    end
  end

  // ****************************************
  // timer clock source and prescaler
  // ****************************************
  // the timer clock is modelled as a one-cycle enable pulse in clk; the pulse marks the
  // rising edge, the midpoint of its period stands for the falling edge
  logic [1:0] div4_q;
  logic [2:0] pre_q;
  logic src_tick, pre_tick, fall_tick;
  logic [3:0] pre_lim;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div4_q <= 2'h0;
    end else begin
      div4_q <= div4_q + 2'h1;
    end
  end

  always_comb begin
    src_tick = link_q.alt_clock_sel ? 1'b1 : (div4_q == `CRT_INSTR_DIV);
    pre_lim = prescaler_en ? (4'h1 << prescale_sel) : 4'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= 3'h0;
    end else if (src_tick) begin
      pre_q <= ({1'b0, pre_q} + 4'h1 >= pre_lim) ? 3'h0 : pre_q + 3'h1;
    end
  end

  // rising edge of the post-prescaler clock
  assign pre_tick = src_tick && ({1'b0, pre_q} + 4'h1 >= pre_lim);
  // falling edge sits half a period after the rising one; only a one-cycle period falls
  // between edges and so shares a clk edge with the increment
  always_comb begin
    if (pre_lim == 4'h1) begin
      fall_tick = link_q.alt_clock_sel || (div4_q == `CRT_INSTR_HALF);
    end else begin
      fall_tick = src_tick && ({1'b0, pre_q} + 4'h1 == (pre_lim >> 1));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_tick_q <= 1'b0;
    end else begin
      timer_tick_q <= pre_tick;
    end
  end

  // ****************************************
  // comparator output latch and gate mux
  // ****************************************
  logic cmp_latch_q, cmp_next;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_latch_q <= 1'b0;
    end else if (fall_tick) begin
      cmp_latch_q <= cmp_s[1];
    end
  end

  // limitation: the unsynced path still passes the two-flop pin synchroniser
  assign cmp_next = link_q.sync_en ? cmp_latch_q : cmp_s[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_out_q <= 1'b0;
      timer_gate_q <= 1'b0;
    end else begin
      cmp_out_q <= cmp_next;
      timer_gate_q <= link_q.gate_source_sel ? gate_s[1] : cmp_next;
    end
  end

  // ****************************************
  // analog control outputs
  // ****************************************
  logic fixed_on;

  assign fixed_on = vref_q.fixed_ref_en || osc_s[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_hysteresis_en <= 1'b0;
      ratio_divider_en <= 1'b0;
      fixed_ref_on <= 1'b0;
      ref_range_sel <= 1'b0;
      ref_level_code <= 4'h0;
      ref_sel_q <= CRT_REF_GND;
    end else begin
      cmp_hysteresis_en <= link_q.hysteresis_en;
      ratio_divider_en <= vref_q.ratio_divider_en;
      fixed_ref_on <= fixed_on;
      ref_range_sel <= vref_q.ref_range_sel;
      ref_level_code <= vref_q.ref_level_code;
      if (vref_q.ratio_divider_en) begin
        ref_sel_q <= CRT_REF_RATIO;
      end else if (fixed_on) begin
        ref_sel_q <= CRT_REF_FIXED;
      end else begin
        ref_sel_q <= CRT_REF_GND;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence link_write_s;
    phase_q == CRT_PH_WRITE && addr_q == `CRT_LINK_CTRL_OFS;
  endsequence

  sequence vref_write_s;
    phase_q == CRT_PH_WRITE && addr_q == `CRT_VREF_CTRL_OFS;
  endsequence

  sequence link_read_s;
    hready && hsel && htrans[1] && !hwrite && haddr[ADDR_W-1:0] == `CRT_LINK_CTRL_OFS;
  endsequence

  AST_SYNC_SELECT: assert property (@(posedge clk) disable iff (rst)
    link_q.sync_en |=> cmp_out_q == $past(cmp_latch_q))
    else $error("synced output does not follow the latch");
  AST_ASYNC_PASS: assert property (@(posedge clk) disable iff (rst)
    !link_q.sync_en |=> cmp_out_q == $past(cmp_s[1]))
    else $error("unsynced output does not follow comparator");
  AST_ALTCLK: assert property (@(posedge clk) disable iff (rst)
    !link_q.alt_clock_sel && src_tick |=> !src_tick || link_q.alt_clock_sel)
    else $error("instruction clock ticks too often");
  AST_GATE_PIN: assert property (@(posedge clk) disable iff (rst)
    link_q.gate_source_sel |=> timer_gate_q == $past(gate_s[1]))
    else $error("gate not from pin");
  AST_HYS: assert property (@(posedge clk) disable iff (rst)
    link_q.hysteresis_en |=> cmp_hysteresis_en)
    else $error("hysteresis not enabled");
  AST_LINK_ZERO: assert property (@(posedge clk) disable iff (rst)
    link_write_s |=> ##1 (link_to_byte(link_q) & ~`CRT_LINK_MASK) == 8'h00)
    else $error("unimplemented link bits hold state");
  AST_RATIO_SEL: assert property (@(posedge clk) disable iff (rst)
    vref_q.ratio_divider_en |=> ref_sel_q == CRT_REF_RATIO && ratio_divider_en)
    else $error("divider not selected");
  AST_FIXED_OSC: assert property (@(posedge clk) disable iff (rst)
    osc_s[1] |=> fixed_ref_on)
    else $error("fixed reference off while fast oscillator runs");
  AST_GND: assert property (@(posedge clk) disable iff (rst)
    !vref_q.ratio_divider_en && !vref_q.fixed_ref_en && !osc_s[1] |=> ref_sel_q == CRT_REF_GND)
    else $error("reference not grounded");
  AST_PRE_TICK: assert property (@(posedge clk) disable iff (rst)
    pre_tick && !fall_tick |=> timer_tick_q)
    else $error("timer tick missing");

  // the latch must never move on the increment edge unless the period is one clk
  AST_NO_RACE: assert property (@(posedge clk) disable iff (rst)
    pre_tick && fall_tick |-> link_q.alt_clock_sel && pre_lim == 4'h1)
    else $error("latch and increment share an edge");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (rst)
    !fall_tick |=> $stable(cmp_latch_q))
    else $error("comparator latch moved off the falling edge");

  // a register write reaches the analog controls two edges later
  AST_RANGE: assert property (@(posedge clk) disable iff (rst)
    vref_write_s |=> ##1 ref_range_sel == $past(wbyte[`CRT_RANGE_BIT], 2))
    else $error("range select does not follow write");
  AST_LEVEL: assert property (@(posedge clk) disable iff (rst)
    vref_write_s |=> ##1 ref_level_code == $past(wbyte[`CRT_LEVEL_LSB +: 4], 2))
    else $error("level code does not follow write");
  AST_FIXED_EN: assert property (@(posedge clk) disable iff (rst)
    vref_write_s |=> ##1 fixed_ref_on == ($past(wbyte[`CRT_FIXED_BIT], 2) || $past(osc_s[1])))
    else $error("fixed reference enable does not follow write");
  AST_DIV_OFF: assert property (@(posedge clk) disable iff (rst)
    !vref_q.ratio_divider_en |=> !ratio_divider_en && ref_sel_q != CRT_REF_RATIO)
    else $error("divider still powered or selected");
  AST_RD_ZERO: assert property (@(posedge clk) disable iff (rst)
    link_read_s |=> (hrdata & ~{24'h00_0000, `CRT_LINK_MASK}) == 32'h0000_0000)
    else $error("unimplemented link bits read nonzero");

  // at release every field still holds its reset value
  AST_RESET_CLEAR: assert property (@(posedge clk)
    $fell(rst) |-> link_q == '0 && vref_q == '0 && ref_sel_q == CRT_REF_GND && !fixed_ref_on)
    else $error("control fields not cleared by reset");

endmodule // crt_ctrl

//--- rtl/crt_cfg.svh
// register offsets, field positions and reset values for the comparator/timer/reference control block
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define CRT_LINK_CTRL_OFS 12'h000
`define CRT_VREF_CTRL_OFS 12'h004

// ****************************************
// field positions
// ****************************************
`define CRT_SYNC_BIT 0
`define CRT_GATE_BIT 1
`define CRT_HYS_BIT 3
`define CRT_ALTCLK_BIT 4
`define CRT_LEVEL_LSB 0
`define CRT_FIXED_BIT 4
`define CRT_RANGE_BIT 5
`define CRT_DIVEN_BIT 7

// ****************************************
// writable masks and reset values
// ****************************************
`define CRT_LINK_MASK 8'h1b
`define CRT_VREF_MASK 8'hbf
`define CRT_LINK_RST 8'h00
`define CRT_VREF_RST 8'h00

// ****************************************
// timing: instruction clock is oscillator divided by four
// ****************************************
`define CRT_INSTR_DIV 2'h3
// instruction-clock count at which its falling edge sits, half a period after the rise
`define CRT_INSTR_HALF 2'h1

`endif

//--- rtl/crt_pkg.sv
// types shared by the comparator/timer/reference control block
package crt_pkg;

  typedef struct packed {
    logic alt_clock_sel;
    logic hysteresis_en;
    logic gate_source_sel;
    logic sync_en;
  } crt_link_t;

  typedef struct packed {
    logic ratio_divider_en;
    logic ref_range_sel;
    logic fixed_ref_en;
    logic [3:0] ref_level_code;
  } crt_vref_t;

  // reference mux selection seen by the analog front end
  typedef enum logic [1:0] {
    CRT_REF_GND = 2'b00,
    CRT_REF_FIXED = 2'b01,
    CRT_REF_RATIO = 2'b11
  } crt_ref_sel_t;

  // ahb data phase tracking
  typedef enum logic [1:0] {
    CRT_PH_IDLE = 2'b00,
    CRT_PH_WRITE = 2'b01,
    CRT_PH_READ = 2'b11
  } crt_phase_t;

endpackage

//--- verification/crt_far_model.sv
// far-side model: comparator front end and timer counter
`timescale 1ns/1ps
module crt_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic clr,
  input wire logic cmp_level,
  input wire logic pin_level,
  output logic cmp_raw,
  output logic gate_pin,
  output logic [15:0] tick_cnt
);
  // ****************************************
  // analog side reduced to commanded levels
  // ****************************************
  assign cmp_raw = cmp_level;
  assign gate_pin = pin_level;
  // ****************************************
  // counter steps on the post-prescaler rising tick
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst || clr) begin
      tick_cnt <= 16'h0000;
    end else if (tick) begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
endmodule // crt_far_model

//--- verification/comparator_ref_timer_control_tb.sv
// testbench for the comparator-timer link and reference control registers
`timescale 1ns/1ps
`include "crt_cfg.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module comparator_ref_timer_control_tb;
  import crt_pkg::*;
  logic clk, rst, hsel, hwrite, cmp_level, pin_level, fosc, pre_en, clr;
  logic hreadyout, hresp, cmp_raw, gate_pin, cmp_q, gate_q, tick, hys, div_en, fix_on, range, hit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, pre_sel;
  logic [3:0] level;
  logic [15:0] tick_cnt;
  crt_ref_sel_t ref_sel;
  int miscompares, cmp_count, n;
  logic [19:0] ttab [5] = '{20'h10050, 20'h00014, 20'h11128, 20'h1130a, 20'h0110a};
  crt_ctrl DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cmp_out_raw(cmp_raw), .timer_gate_pin(gate_pin), .fast_internal_osc(fosc),
    .prescaler_en(pre_en), .prescale_sel(pre_sel), .cmp_out_q(cmp_q), .timer_gate_q(gate_q),
    .timer_tick_q(tick), .cmp_hysteresis_en(hys), .ratio_divider_en(div_en), .fixed_ref_on(fix_on),
    .ref_range_sel(range), .ref_level_code(level), .ref_sel_q(ref_sel));
  crt_far_model far (.clk(clk), .rst(rst), .tick(tick), .clr(clr), .cmp_level(cmp_level),
    .pin_level(pin_level), .cmp_raw(cmp_raw), .gate_pin(gate_pin), .tick_cnt(tick_cnt));
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin miscompares++; test_done; end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] wd);
    hsel <= 1'b1; haddr <= {20'h00000, a}; htrans <= 2'h2; hwrite <= w;
    wait_ready;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h000000, wd};
    wait_ready;
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; cmp_level = 0; pin_level = 0;
    fosc = 0; pre_en = 0; pre_sel = 0; clr = 0; miscompares = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(hresp, 1'b0)
    rd_chk(`CRT_LINK_CTRL_OFS, 8'h00);
    rd_chk(`CRT_VREF_CTRL_OFS, 8'h00);
    rd_chk(12'h008, 8'h00);
    `CHK(ref_sel, CRT_REF_GND)
    xfer(1'b1, `CRT_LINK_CTRL_OFS, 8'hff);
    rd_chk(`CRT_LINK_CTRL_OFS, 8'h1b);
    xfer(1'b1, `CRT_VREF_CTRL_OFS, 8'hff);
    rd_chk(`CRT_VREF_CTRL_OFS, 8'hbf);
    settle;
    `CHK(hys, 1'b1)
    `CHK(div_en, 1'b1)
    `CHK(ref_sel, CRT_REF_RATIO)
    `CHK(range, 1'b1)
    `CHK(level, 4'hf)
    `CHK(fix_on, 1'b1)
    xfer(1'b1, `CRT_VREF_CTRL_OFS, 8'h05);
    settle;
    `CHK({range, level, div_en}, 6'h0a)
    `CHK(ref_sel, CRT_REF_GND)
    `CHK(fix_on, 1'b0)
    fosc <= 1'b1;
    settle;
    `CHK(fix_on, 1'b1)
    fosc <= 1'b0;
    xfer(1'b1, `CRT_VREF_CTRL_OFS, 8'h1a);
    settle;
    `CHK(ref_sel, CRT_REF_FIXED)
    `CHK(level, 4'ha)
    // gate from the pin with sync and hysteresis on, then from the comparator unsynced
    for (int i = 0; i < 8; i++) begin
      if (i == 4) xfer(1'b1, `CRT_LINK_CTRL_OFS, 8'h00);
      {cmp_level, pin_level} <= i[1:0];
      settle;
      `CHK(gate_q, (i < 4) ? i[0] : i[1])
      `CHK(cmp_q, i[1])
      `CHK(hys, (i < 4) ? 1'b1 : 1'b0)
    end
    // tick rate: {alt, pre_en, pre_sel, expected ticks in 80 cycles}
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, `CRT_LINK_CTRL_OFS, {3'h0, ttab[i][16], 4'h0});
      pre_en <= ttab[i][12];
      pre_sel <= ttab[i][9:8];
      settle;
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (80) @(posedge clk);
      // look once the last counted edge has landed
      @(negedge clk);
      `CHK(tick_cnt, {8'h00, ttab[i][7:0]})
      @(posedge clk);
    end
    // comparator gates the timer with the sync bit set, so the output is synchronised
    xfer(1'b1, `CRT_LINK_CTRL_OFS, 8'h01);
    pre_en <= 1'b1;
    pre_sel <= 2'h3;
    for (int i = 0; i < 2; i++) begin
      cmp_level <= ~cmp_level;
      hit = 1'b0;
      for (n = 0; n < 80 && !hit; n++) begin
        @(posedge clk);
        hit = (cmp_q === cmp_level);
      end
      `CHK(hit, 1'b1)
    end
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(`CRT_LINK_CTRL_OFS, 8'h00);
    test_done;
  end
endmodule // comparator_ref_timer_control_tb
